// *** hw/sfb_front_end.sv ***
// Serial bus front end: lane shifting, select, pause, status lock-down,
// page and erase address handling of an 8 Mbit serial flash.
// Assumes a core on I_REF_CLK that decodes bytes and supplies read data.
`timescale 1ns/1ns

// Behaviour
// RULE1: single lane samples serial_in on rise
// RULE2: single lane read data changes on fall
// RULE3: dual/quad lanes bidirectional, same edges
// RULE4: deselected floats all lanes, jobs continue
// RULE5: select low accepts instructions and reads
// RULE6: ignore instructions before first select fall
// RULE7: pause floats output, ignores clock, input
// RULE8: pause only in single and dual
// RULE9: pause needs pause_pin_enable set first
// RULE10: lock-down blocks status writes when pin low
// RULE11: pin high allows status writes always
// RULE12: accept clock mode 0 or 3
// RULE13: page program takes 1 to 256 bytes
// RULE14: programming only clears bits per page
// RULE15: erase sector, block, chip; no page
// RULE16: array 1 MB as 4096 pages
// RULE17: uniform 64K/32K/4K/2K/1K erase units
// RULE18: erase units aligned on address ranges
// RULE19: dual/quad repurpose pins as lanes
// RULE20: same edges whatever the clock idle level
// RULE21: host keeps program bytes in one page
// RULE22: unit indices from upper address bits
module sfb_front_end #(
    parameter int PAGE_BYTES = sfb_pkg::PAGE_BYTES
) (
    input  wire logic                     I_REF_CLK,
    input  wire logic                     I_RESET,
    input  wire logic                     I_CE,
    input  wire logic                     I_SCLK,
    input  wire logic                     I_SELECT_N,
    input  wire logic                     I_IO_LANE0,
    input  wire logic                     I_IO_LANE1,
    input  wire logic                     I_IO_LANE2,
    input  wire logic                     I_IO_LANE3,
    output logic                          O_IO_LANE0,
    output logic                          O_IO_LANE1,
    output logic                          O_IO_LANE2,
    output logic                          O_IO_LANE3,
    output logic                          O_IO_LANE0_OE,
    output logic                          O_IO_LANE1_OE,
    output logic                          O_IO_LANE2_OE,
    output logic                          O_IO_LANE3_OE,
    input  wire sfb_pkg::sfb_cmd_t        i_cmd,
    input  wire logic                     i_cmd_valid,
    input  wire logic [7:0]               i_rd_byte,
    input  wire logic                     i_busy,
    input  wire logic                     i_lockdown,
    output logic [7:0]                    o_rx_byte,
    output logic                          o_rx_valid,
    output logic                          o_frame_start,
    output logic                          o_status_wr_ok,
    output logic                          o_status_wr_rej,
    output logic                          o_pause_en,
    output logic [sfb_pkg::ADDR_W-1:0]    o_prog_addr,
    output logic                          o_prog_strobe,
    output logic                          o_prog_overflow,
    output sfb_pkg::sfb_index_t           o_erase_index
);
    if (PAGE_BYTES != sfb_pkg::PAGE_BYTES) begin : g_bad_page
        $error("Page size must match the array page");
    end

    // Link domain: serial clock shift logic
    logic        paused;
    logic [1:0]  lanes_c;
    logic        dir_out_c;
    logic [7:0]  rd_hold;
    logic        frame_armed;
    logic [7:0]  rx_shift;
    logic [2:0]  rx_cnt;
    logic        rx_tgl;
    logic [7:0]  rx_hold;
    logic [7:0]  tx_shift;
    logic [3:0]  tx_out;
    logic [2:0]  tx_cnt;
    logic        frame_tgl;
    logic        seen_fall;
    logic [1:0]  lanes_l_s;
    logic [1:0]  lanes_l;
    logic        dir_out_s;
    logic        dir_out_l;
    logic        pause_en_s;
    logic        pause_en_l;

    wire quad_l   = (lanes_l == 2'(sfb_pkg::SFB_LANE_FOUR));
    wire dual_l   = (lanes_l == 2'(sfb_pkg::SFB_LANE_TWO));
    // RULE7: pause pin low halts the link
    // RULE8: quad uses the pin as lane 3
    // RULE9: only when enabled by status write
    wire pause_req = pause_en_l && !quad_l && !I_IO_LANE3;
    wire active    = !I_SELECT_N && !paused && seen_fall;

    // RULE6: first select fall arms the link
    always_ff @(negedge I_SELECT_N or posedge I_RESET) begin
        if (I_RESET) begin
            seen_fall <= 1'b0;
        end else begin
            seen_fall <= 1'b1;
        end
    end

    // Pause takes effect only with the clock low, as for the usual hold
    always_ff @(negedge I_SCLK or posedge I_SELECT_N) begin
        if (I_SELECT_N) begin
            paused <= 1'b0;
        end else begin
            paused <= pause_req;
        end
    end

    // Lane setup from the core, crossed into the link domain
    always_ff @(posedge I_SCLK or posedge I_RESET) begin
        if (I_RESET) begin
            lanes_l_s  <= 2'h0;
            lanes_l    <= 2'h0;
            dir_out_s  <= 1'b0;
            dir_out_l  <= 1'b0;
            pause_en_s <= 1'b0;
            pause_en_l <= 1'b0;
        end else begin
            lanes_l_s  <= lanes_c;
            lanes_l    <= lanes_l_s;
            dir_out_s  <= dir_out_c;
            dir_out_l  <= dir_out_s;
            pause_en_s <= o_pause_en;
            pause_en_l <= pause_en_s;
        end
    end

    // RULE1: sample on rising edge
    // RULE3: multi-lane input on rising edge
    // RULE12: mode 0 and 3 share edges
    // RULE20: idle level does not matter
    always_ff @(posedge I_SCLK or posedge I_SELECT_N) begin
        if (I_SELECT_N) begin
            rx_shift <= 8'h00;
            rx_cnt   <= 3'h0;
        end else if (active && !dir_out_l) begin
            unique case (lanes_l)
                2'(sfb_pkg::SFB_LANE_FOUR): begin
                    rx_shift <= {rx_shift[3:0], I_IO_LANE3, I_IO_LANE2,
                                 I_IO_LANE1, I_IO_LANE0};
                    rx_cnt   <= rx_cnt + 3'h4;
                end
                2'(sfb_pkg::SFB_LANE_TWO): begin
                    rx_shift <= {rx_shift[5:0], I_IO_LANE1, I_IO_LANE0};
                    rx_cnt   <= rx_cnt + 3'h2;
                end
                default: begin
                    rx_shift <= {rx_shift[6:0], I_IO_LANE0};
                    rx_cnt   <= rx_cnt + 3'h1;
                end
            endcase
        end
    end

    wire [7:0] rx_next = quad_l ? {rx_shift[3:0], I_IO_LANE3, I_IO_LANE2,
                                   I_IO_LANE1, I_IO_LANE0}
                       : dual_l ? {rx_shift[5:0], I_IO_LANE1, I_IO_LANE0}
                       : {rx_shift[6:0], I_IO_LANE0};
    wire [2:0] step = quad_l ? 3'h4 : (dual_l ? 3'h2 : 3'h1);
    wire       byte_done = (3'(rx_cnt + step) == 3'h0);

    // Byte handover by toggle; held word is stable for many core cycles
    always_ff @(posedge I_SCLK or posedge I_RESET) begin
        if (I_RESET) begin
            rx_tgl  <= 1'b0;
            rx_hold <= 8'h00;
        end else if (active && !dir_out_l && byte_done) begin
            rx_tgl  <= ~rx_tgl;
            rx_hold <= rx_next;
        end
    end

    // RULE2: output changes on falling edge
    // RULE3: multi-lane output on falling edge
    always_ff @(negedge I_SCLK or posedge I_SELECT_N) begin
        if (I_SELECT_N) begin
            tx_shift <= 8'h00;
            tx_out   <= 4'h0;
            tx_cnt   <= 3'h0;
        end else if (active && dir_out_l) begin
            if (tx_cnt == 3'h0) begin
                tx_shift <= rd_hold;
                tx_out   <= quad_l ? rd_hold[7:4]
                          : dual_l ? {2'h0, rd_hold[7:6]}
                          : {2'h0, rd_hold[7], 1'b0};
            end else begin
                tx_out   <= quad_l ? tx_shift[7:4]
                          : dual_l ? {2'h0, tx_shift[7:6]}
                          : {2'h0, tx_shift[7], 1'b0};
            end
            tx_shift <= (tx_cnt == 3'h0 ? rd_hold : tx_shift)
                        << (quad_l ? 4 : (dual_l ? 2 : 1));
            tx_cnt   <= 3'(tx_cnt + step);
        end
    end

    always_ff @(posedge I_SCLK or posedge I_RESET) begin
        if (I_RESET) begin
            frame_tgl <= 1'b0;
        end else if (active && rx_cnt == 3'h0 && !dir_out_l
                     && rx_shift == 8'h00 && !frame_armed) begin
            frame_tgl <= ~frame_tgl;
        end
    end
    always_ff @(posedge I_SCLK or posedge I_SELECT_N) begin
        if (I_SELECT_N) begin
            frame_armed <= 1'b0;
        end else if (active) begin
            frame_armed <= 1'b1;
        end
    end

    // RULE4: deselect floats every lane
    // RULE19: lanes 2 and 3 drive only in quad
    wire drive = active && dir_out_l;
    assign O_IO_LANE0    = tx_out[0];
    assign O_IO_LANE1    = quad_l || dual_l ? tx_out[1] : tx_out[1] | tx_out[2];
    assign O_IO_LANE2    = tx_out[2];
    assign O_IO_LANE3    = tx_out[3];
    assign O_IO_LANE0_OE = drive && (quad_l || dual_l);
    assign O_IO_LANE1_OE = drive;
    assign O_IO_LANE2_OE = drive && quad_l;
    assign O_IO_LANE3_OE = drive && quad_l;

    // Core domain
    logic [2:0]  rx_sync;
    logic [2:0]  fr_sync;
    logic [1:0]  sel_sync;
    logic [1:0]  lock_sync;
    logic [sfb_pkg::ADDR_W-1:0] page_base;
    logic [8:0]  prog_cnt;
    logic        cmd_done;

    wire rx_evt  = rx_sync[2] ^ rx_sync[1];
    wire fr_evt  = fr_sync[2] ^ fr_sync[1];
    wire sel_c   = !sel_sync[1];
    wire is_swr  = (i_cmd.op == sfb_pkg::SFB_OP_SWR)
                || (i_cmd.op == sfb_pkg::SFB_OP_SWR4);
    // RULE10: pin low with lock-down rejects
    // RULE11: pin high always executes
    wire swr_ok  = lock_sync[1] || !i_lockdown;
    wire cmd_go  = i_cmd_valid && sel_c && !cmd_done;
    wire is_prog = (i_cmd.op == sfb_pkg::SFB_OP_PROG);
    // RULE13: up to a full page of bytes
    wire prog_full = (prog_cnt == 9'(PAGE_BYTES));

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rx_sync   <= 3'h0;
            fr_sync   <= 3'h0;
            sel_sync  <= 2'h3;
            lock_sync <= 2'h0;
        end else if (I_CE) begin
            rx_sync   <= {rx_sync[1:0], rx_tgl};
            fr_sync   <= {fr_sync[1:0], frame_tgl};
            sel_sync  <= {sel_sync[0], I_SELECT_N};
            lock_sync <= {lock_sync[0], I_IO_LANE2};
        end
    end

    // RULE5: selected frame accepts commands
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_rx_byte       <= 8'h00;
            o_rx_valid      <= 1'b0;
            o_frame_start   <= 1'b0;
            o_status_wr_ok  <= 1'b0;
            o_status_wr_rej <= 1'b0;
            o_pause_en      <= sfb_pkg::RST_PAUSE_EN;
            lanes_c         <= 2'h0;
            dir_out_c       <= 1'b0;
            rd_hold         <= 8'h00;
            cmd_done        <= 1'b0;
        end else if (I_CE) begin
            o_rx_valid      <= rx_evt;
            o_frame_start   <= fr_evt;
            o_status_wr_ok  <= 1'b0;
            o_status_wr_rej <= 1'b0;
            if (rx_evt) begin
                o_rx_byte <= rx_hold;
            end
            rd_hold <= i_rd_byte;
            if (!sel_c) begin
                lanes_c   <= 2'h0;
                dir_out_c <= 1'b0;
                cmd_done  <= 1'b0;
            end else if (i_cmd_valid) begin
                lanes_c   <= i_cmd.lanes;
                dir_out_c <= (i_cmd.op == sfb_pkg::SFB_OP_READ)
                          || (i_cmd.op == sfb_pkg::SFB_OP_QREAD);
            end
            // RULE4: busy core jobs run regardless
            if (cmd_go && is_swr && !i_busy) begin
                cmd_done        <= 1'b1;
                o_status_wr_ok  <= swr_ok;
                o_status_wr_rej <= !swr_ok;
                // RULE9: set via the fourth status write
                if (swr_ok && i_cmd.op == sfb_pkg::SFB_OP_SWR4) begin
                    o_pause_en <= i_cmd.wr_byte[sfb_pkg::PAUSE_EN_BIT];
                end
            end
        end
    end

    // RULE14: one page at a time
    // RULE21: address wraps within the page
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            page_base       <= '0;
            prog_cnt        <= 9'h000;
            o_prog_addr     <= '0;
            o_prog_strobe   <= 1'b0;
            o_prog_overflow <= 1'b0;
        end else if (I_CE) begin
            o_prog_strobe <= 1'b0;
            if (!sel_c) begin
                prog_cnt        <= 9'h000;
                o_prog_overflow <= 1'b0;
                page_base       <= i_cmd.addr;
            end else if (is_prog && i_cmd_valid && rx_evt) begin
                if (prog_full) begin
                    o_prog_overflow <= 1'b1;
                end else begin
                    o_prog_strobe <= 1'b1;
                    prog_cnt      <= 9'(prog_cnt + 9'h001);
                end
                o_prog_addr <= {page_base[sfb_pkg::ADDR_W-1:8],
                                8'(page_base[7:0] + prog_cnt[7:0])};
            end
        end
    end

    // RULE15: no page granularity erase
    // RULE16: 20 address bits span the array
    // RULE17: uniform unit sizes
    // RULE18: units aligned by address bits
    // RULE22: indices from upper address bits
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_erase_index <= '0;
        end else if (I_CE && i_cmd_valid
                     && i_cmd.op == sfb_pkg::SFB_OP_ERASE) begin
            o_erase_index.sec1k <= i_cmd.addr[sfb_pkg::ARRAY_MSB:
                                              sfb_pkg::SEC1K_LSB];
            o_erase_index.sec2k <= i_cmd.addr[sfb_pkg::ARRAY_MSB:
                                              sfb_pkg::SEC2K_LSB];
            o_erase_index.sec4k <= i_cmd.addr[sfb_pkg::ARRAY_MSB:
                                              sfb_pkg::SEC4K_LSB];
            o_erase_index.blk32 <= i_cmd.addr[sfb_pkg::ARRAY_MSB:
                                              sfb_pkg::BLK32_LSB];
            o_erase_index.blk64 <= i_cmd.addr[sfb_pkg::ARRAY_MSB:
                                              sfb_pkg::BLK64_LSB];
        end
    end
endmodule

// *** include/sfb_pkg.sv ***
// Shared constants and carriers for the serial flash bus front end.
// Assumes a host that drives the serial clock in mode 0 or mode 3.
package sfb_pkg;
    localparam int ADDR_W        = 24;
    localparam int ARRAY_BYTES   = 1048576;
    localparam int PAGE_BYTES    = 256;
    localparam int PAGE_COUNT    = 4096;
    localparam int SEC1K_LSB     = 10;
    localparam int SEC2K_LSB     = 11;
    localparam int SEC4K_LSB     = 12;
    localparam int BLK32_LSB     = 15;
    localparam int BLK64_LSB     = 16;
    localparam int ARRAY_MSB     = 19;
    localparam int PAUSE_EN_BIT  = 2;
    localparam logic RST_PAUSE_EN = 1'b0;
    localparam logic RST_LOCKDOWN = 1'b0;

    typedef enum logic [6:0] {
        SFB_OP_NONE   = 7'h01,
        SFB_OP_SWR    = 7'h02,
        SFB_OP_SWR4   = 7'h04,
        SFB_OP_PROG   = 7'h08,
        SFB_OP_ERASE  = 7'h10,
        SFB_OP_READ   = 7'h20,
        SFB_OP_QREAD  = 7'h40
    } sfb_op_t;

    typedef enum logic [1:0] {
        SFB_LANE_ONE  = 2'h0,
        SFB_LANE_TWO  = 2'h1,
        SFB_LANE_FOUR = 2'h2
    } sfb_lanes_t;

    typedef enum logic [2:0] {
        SFB_ER_1K   = 3'h0,
        SFB_ER_2K   = 3'h1,
        SFB_ER_4K   = 3'h2,
        SFB_ER_32K  = 3'h3,
        SFB_ER_64K  = 3'h4,
        SFB_ER_CHIP = 3'h5
    } sfb_erase_t;

    // Erase unit indices taken from one address
    typedef struct packed {
        logic [9:0] sec1k;
        logic [8:0] sec2k;
        logic [7:0] sec4k;
        logic [4:0] blk32;
        logic [3:0] blk64;
    } sfb_index_t;

    // Decoded instruction presented by the core
    typedef struct packed {
        sfb_op_t          op;
        sfb_lanes_t       lanes;
        logic [7:0]       wr_byte;
        logic [ADDR_W-1:0] addr;
    } sfb_cmd_t;
endpackage

// *** testbench/sfb_front_end_props.sv ***
// Checker on front end ports: lanes, status verdicts, page, indices.
// Assumes the bind below; all properties run on the core clock.
`timescale 1ns/1ns
module sfb_props #(
    parameter int PAGE_BYTES = 256
) (
    input wire logic                        I_REF_CLK,
    input wire logic                        I_RESET,
    input wire logic                        I_SELECT_N,
    input wire logic                        I_IO_LANE2,
    input wire logic                        O_IO_LANE0_OE,
    input wire logic                        O_IO_LANE1_OE,
    input wire logic                        O_IO_LANE2_OE,
    input wire logic                        O_IO_LANE3_OE,
    input wire logic                        i_lockdown,
    input wire logic                        o_rx_valid,
    input wire logic                        o_status_wr_ok,
    input wire logic                        o_status_wr_rej,
    input wire logic                        o_pause_en,
    input wire logic [sfb_pkg::ADDR_W-1:0]  o_prog_addr,
    input wire logic                        o_prog_strobe,
    input wire sfb_pkg::sfb_index_t         o_erase_index
);
    logic [23:0] pg;
    logic        seen;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    // Page of the latest program byte in this frame
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            seen <= 1'b0;
            pg <= 24'h0;
        end else if (I_SELECT_N) begin
            seen <= 1'b0;
        end else if (o_prog_strobe) begin
            seen <= 1'b1;
            pg <= 24'(o_prog_addr / PAGE_BYTES);
        end
    end
    chk_float_deselect: assert property (I_SELECT_N [*3] |->
        !(O_IO_LANE0_OE | O_IO_LANE1_OE | O_IO_LANE2_OE | O_IO_LANE3_OE))
        else $error("lane driven while deselected");
    chk_rx_one_pulse: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("receive pulse too long");
    chk_verdict_single: assert property (
        !(o_status_wr_ok && o_status_wr_rej))
        else $error("status write both taken and refused");
    chk_pin_high_bypass: assert property (
        I_IO_LANE2 [*4] |-> !o_status_wr_rej)
        else $error("refused with protect pin high");
    chk_unlocked_allows: assert property (
        !i_lockdown [*4] |-> !o_status_wr_rej)
        else $error("refused while unlocked");
    chk_pause_off_reset: assert property ($fell(I_RESET) |-> !o_pause_en)
        else $error("pause enabled out of reset");
    chk_prog_one_page: assert property (
        o_prog_strobe && seen |-> o_prog_addr / PAGE_BYTES == pg)
        else $error("program left its page");
    chk_index_nested: assert property (o_erase_index.blk64 ==
        o_erase_index.sec1k[9:6] && o_erase_index.blk32 ==
        o_erase_index.sec1k[9:5] && o_erase_index.sec4k ==
        o_erase_index.sec1k[9:2] && o_erase_index.sec2k ==
        o_erase_index.sec1k[9:1])
        else $error("erase indices disagree");
    chk_quad_all_lanes: assert property (O_IO_LANE2_OE |->
        O_IO_LANE3_OE && O_IO_LANE0_OE && O_IO_LANE1_OE)
        else $error("quad lanes not driven together");
    chk_dual_pair: assert property (O_IO_LANE0_OE |-> O_IO_LANE1_OE)
        else $error("lane0 driven without lane1");
endmodule

bind sfb_front_end sfb_props #(.PAGE_BYTES(PAGE_BYTES)) props_u (
    .I_REF_CLK, .I_RESET, .I_SELECT_N, .I_IO_LANE2, .O_IO_LANE0_OE,
    .O_IO_LANE1_OE, .O_IO_LANE2_OE, .O_IO_LANE3_OE, .i_lockdown,
    .o_rx_valid, .o_status_wr_ok, .o_status_wr_rej, .o_pause_en,
    .o_prog_addr, .o_prog_strobe, .o_erase_index
);

// *** testbench/sfb_host_model.sv ***
// Host side of the serial bus: select, clock, host-driven lanes.
// Assumes the bench resolves lane levels from both sides' enables.
`timescale 1ns/1ns
module sfb_host_model (
    output logic       o_sclk,
    output logic       o_select_n,
    output logic [3:0] o_dat,
    output logic [3:0] o_en
);
    logic idle_lvl;
    initial begin
        idle_lvl = 1'b0;
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_dat = 4'hc;
        o_en = 4'hd;
    end
    // clock idles at the mode level
    task automatic begin_frame(input logic mode3);
        idle_lvl = mode3;
        o_sclk = mode3;
        #40;
        o_select_n = 1'b0;
        #40;
    endtask
    // data set while low, taken on rise
    task automatic send_bit(input logic d);
        o_sclk = 1'b0;
        o_dat[0] = d;
        #8 o_sclk = 1'b1;
        #7;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) send_bit(b[i]);
    endtask
    task automatic dummy(input int n);
        repeat (n) send_bit(o_dat[0]);
    endtask
    // Clock stands still outside frames
    task automatic end_frame();
        o_sclk = idle_lvl;
        #20 o_select_n = 1'b1;
        #60;
    endtask
    task automatic set_pins(input logic wp, input logic pause);
        o_dat[2] = wp;
        o_dat[3] = pause;
    endtask
    // host lets go of all lanes for quad reads
    task automatic release_lanes(input logic quad);
        o_en = quad ? 4'h0 : 4'hd;
    endtask
endmodule

// *** testbench/test_sfb_front_end.sv ***
// Self-checking bench for the serial flash bus front end.
// Assumes the host model drives the link and the bench the core side.
`timescale 1ns/1ns
module test_sfb_front_end;
    logic clk, rst, cmd_valid, busy, lockdown, last_rej, over, pen, ce;
    logic [7:0] rd_byte, rx_byte, last_rx;
    logic [23:0] paddr, prog_q[$];
    logic rx_valid, wr_ok, wr_rej, pstb, fst;
    sfb_pkg::sfb_cmd_t cmd;
    sfb_pkg::sfb_index_t eidx;
    wire sclk, sel_n;
    wire [3:0] h_dat, h_en, d_o, d_oe, lane;
    int bad_count = 0, total_checks = 0, rx_cnt = 0, vcnt = 0, fcnt = 0;
    // Released lanes show the inverse of their last level
    assign lane = (d_oe & d_o) | (~d_oe & ~(h_en ^ h_dat));
    sfb_host_model host_u (.o_sclk(sclk), .o_select_n(sel_n),
        .o_dat(h_dat), .o_en(h_en));
    sfb_front_end dut_u (.I_REF_CLK(clk), .I_RESET(rst), .I_CE(ce),
        .I_SCLK(sclk), .I_SELECT_N(sel_n), .I_IO_LANE0(lane[0]),
        .I_IO_LANE1(lane[1]), .I_IO_LANE2(lane[2]), .I_IO_LANE3(lane[3]),
        .O_IO_LANE0(d_o[0]), .O_IO_LANE1(d_o[1]), .O_IO_LANE2(d_o[2]),
        .O_IO_LANE3(d_o[3]), .O_IO_LANE0_OE(d_oe[0]),
        .O_IO_LANE1_OE(d_oe[1]), .O_IO_LANE2_OE(d_oe[2]),
        .O_IO_LANE3_OE(d_oe[3]), .i_cmd(cmd), .i_cmd_valid(cmd_valid),
        .i_rd_byte(rd_byte), .i_busy(busy), .i_lockdown(lockdown),
        .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_frame_start(fst),
        .o_status_wr_ok(wr_ok), .o_status_wr_rej(wr_rej),
        .o_pause_en(pen), .o_prog_addr(paddr), .o_prog_strobe(pstb),
        .o_prog_overflow(over), .o_erase_index(eidx));
    always @(posedge clk) begin
        if (rx_valid) begin
            last_rx <= rx_byte;
            rx_cnt <= rx_cnt + 1;
        end
        if (wr_ok | wr_rej) begin
            last_rej <= wr_rej;
            vcnt <= vcnt + 1;
        end
        if (pstb) prog_q.push_back(paddr);
        if (fst) fcnt <= fcnt + 1;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic issue(input sfb_pkg::sfb_op_t op,
        input sfb_pkg::sfb_lanes_t ln, input logic [7:0] wr,
        input logic [23:0] a);
        @(posedge clk);
        cmd <= '{op: op, lanes: ln, wr_byte: wr, addr: a};
        cmd_valid <= 1'b1;
    endtask
    task automatic drop();
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic t_rx(input logic mode3, input logic [7:0] b);
        int n0, f0;
        n0 = rx_cnt;
        f0 = fcnt;
        host_u.begin_frame(mode3);
        host_u.send_byte(b);
        for (int i = 0; i < 20 && rx_cnt == n0; i++) @(negedge clk);
        check(last_rx, b);
        check(fcnt - f0, 1);
        host_u.end_frame();
    endtask
    task automatic t_status(input logic wp, input logic lock,
        input logic hold, input sfb_pkg::sfb_op_t op, input logic [7:0] wr,
        input logic rej);
        int n0;
        host_u.set_pins(wp, 1'b1);
        @(posedge clk);
        lockdown <= lock;
        busy <= hold;
        host_u.begin_frame(1'b0);
        n0 = vcnt;
        issue(op, sfb_pkg::SFB_LANE_ONE, wr, 24'h0);
        if (hold) begin
            repeat (6) @(negedge clk);
            check(vcnt, n0);
            // Clock enable low must hold the write back too
            @(posedge clk);
            busy <= 1'b0;
            ce <= 1'b0;
            repeat (6) @(negedge clk);
            check(vcnt, n0);
            @(posedge clk);
            ce <= 1'b1;
        end
        for (int i = 0; i < 30 && vcnt == n0; i++) @(negedge clk);
        check({vcnt - n0, last_rej}, {32'h1, rej});
        drop();
        host_u.end_frame();
    endtask
    task automatic t_read_pause();
        @(posedge clk);
        rd_byte <= 8'h9d;
        host_u.begin_frame(1'b0);
        issue(sfb_pkg::SFB_OP_READ, sfb_pkg::SFB_LANE_ONE, 8'h00, 24'h100);
        repeat (3) @(negedge clk);
        host_u.dummy(6);
        check(d_oe, 4'h2);
        check(d_o[1], 1'b1);
        host_u.set_pins(1'b1, 1'b0);
        host_u.dummy(2);
        check(d_oe[1], 1'b0);
        host_u.set_pins(1'b1, 1'b1);
        host_u.dummy(2);
        check(d_oe, 4'h2);
        drop();
        host_u.end_frame();
        repeat (4) @(negedge clk);
        check(d_oe, 4'h0);
    endtask
    // Pause pin floats low here, yet quad keeps lane3 as data
    task automatic t_quad();
        host_u.begin_frame(1'b1);
        host_u.release_lanes(1'b1);
        issue(sfb_pkg::SFB_OP_QREAD, sfb_pkg::SFB_LANE_FOUR, 8'h00, 24'h0);
        repeat (3) @(negedge clk);
        host_u.dummy(6);
        check(d_oe, 4'hf);
        drop();
        host_u.end_frame();
        host_u.release_lanes(1'b0);
    endtask
    // One byte past the page limit, starting near the page end
    task automatic t_prog();
        prog_q.delete();
        // bytes follow on at one page's addresses
        issue(sfb_pkg::SFB_OP_PROG, sfb_pkg::SFB_LANE_ONE, 8'h00, 24'h0ffffe);
        host_u.begin_frame(1'b0);
        repeat (3) @(negedge clk);
        // Two clocks let the single-lane setup reach the link
        host_u.dummy(2);
        repeat (257) host_u.send_byte(8'h5a);
        repeat (10) @(negedge clk);
        check(prog_q.size(), 256);
        check(over, 1'b1);
        check(prog_q[0], 24'h0ffffe);
        check(prog_q[2], 24'h0fff00);
        drop();
        host_u.end_frame();
    endtask
    task automatic t_erase(input logic [23:0] a, input logic [35:0] e);
        host_u.begin_frame(1'b0);
        issue(sfb_pkg::SFB_OP_ERASE, sfb_pkg::SFB_LANE_ONE, 8'h00, a);
        repeat (6) @(negedge clk);
        check(eidx, e);
        drop();
        host_u.end_frame();
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        busy = 1'b0;
        lockdown = 1'b0;
        ce = 1'b1;
        rd_byte = 8'hc6;
        cmd = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(d_oe, 4'h0);
        check(pen, 1'b0);
        t_rx(1'b0, 8'ha5);
        t_rx(1'b1, 8'h3c);
        t_status(1'b0, 1'b1, 1'b0, sfb_pkg::SFB_OP_SWR, 8'h00, 1'b1);
        t_status(1'b0, 1'b0, 1'b1, sfb_pkg::SFB_OP_SWR, 8'h00, 1'b0);
        t_status(1'b1, 1'b1, 1'b0, sfb_pkg::SFB_OP_SWR4, 8'h00, 1'b0);
        check(pen, 1'b0);
        t_status(1'b1, 1'b0, 1'b0, sfb_pkg::SFB_OP_SWR4, 8'h04, 1'b0);
        check(pen, 1'b1);
        t_read_pause();
        t_quad();
        t_prog();
        t_erase(24'h0ffc00, {10'h3ff, 9'h1ff, 8'hff, 5'h1f, 4'hf});
        t_erase(24'h0f0000, {10'h3c0, 9'h1e0, 8'hf0, 5'h1e, 4'hf});
        t_erase(24'h080000, {10'h200, 9'h100, 8'h80, 5'h10, 4'h8});
        give_verdict();
    end
endmodule
